// ==== src/dmu_pkg.sv ====
// package: constants, field layout, state record and helper functions
// for the instruction hold and data manipulation datapath.
// assumes a single processor clock and odd parity per byte.
package dmu_pkg;
    localparam int WORD_W = 32;
    localparam int BUS_W = 36;
    localparam int MIR_W = 48;
    // ------------------------------------------------------------
    // microinstruction word fields
    // ------------------------------------------------------------
    localparam int MIR_OP_LO = 0;
    localparam int MIR_MASK_EN = 3;
    localparam int MIR_MASK_CIH = 4;
    localparam int MIR_GATE_AND = 5;
    localparam int MIR_BYPASS = 6;
    localparam int MIR_BYP_LIT = 7;
    localparam int MIR_FLZ = 8;
    localparam int MIR_ROT_CIH = 9;
    localparam int MIR_REG_LO = 12;
    localparam int MIR_LIT_LO = 16;
    localparam int MIR_MADDR_LO = 16;
    localparam int MIR_KIND_LO = 40;
    // ------------------------------------------------------------
    // hold register fields, codes, reset values
    // ------------------------------------------------------------
    localparam int CIH_ROT_LO = 0;
    localparam int CIH_REG_LO = 20;
    localparam logic [3:0] REG_INDIRECT = 4'hf;
    localparam logic [3:0] KIND_EXT = 4'h0;
    localparam logic [3:0] KIND_CIH = 4'h1;
    localparam logic [3:0] KIND_HSW = 4'h2;
    localparam logic [3:0] KIND_SSW = 4'h3;
    localparam logic [3:0] KIND_FIL = 4'h4;
    localparam logic [2:0] OP_PASS = 3'h0;
    localparam logic [2:0] OP_ADD = 3'h1;
    localparam logic [2:0] OP_SUB = 3'h2;
    localparam logic [2:0] OP_OR = 3'h3;
    localparam logic [2:0] OP_AND = 3'h4;
    localparam logic [2:0] OP_XOR = 3'h5;
    localparam logic [31:0] HSW_RO_MASK = 32'h0000_00f0;
    localparam logic [31:0] SSW_WR_MASK_DEF = 32'h0000_ffff;
    localparam logic [35:0] BUS_RST = 36'hf_0000_0000;
    localparam logic [31:0] FLZ_NONE = 32'h0000_0020;

    typedef struct packed {
        logic [35:0] fil;
        logic [35:0] cih;
        logic [35:0] dst;
        logic [31:0] hsw;
        logic [31:0] ssw;
        logic [31:0] alu0;
        logic cmp_pend;
        logic manip_err_n;
        logic cih_perr;
        logic [3:0] gen_sel;
        logic [7:0] uaddr;
        logic [31:0] ssw_s1;
        logic [31:0] ssw_s2;
        logic [3:0] hro_s1;
        logic [3:0] hro_s2;
    } dmu_state_t;

    // odd parity, one bit per byte, byte 3 in the top bit
    function automatic logic [3:0] par4(input logic [31:0] w);
        for (int i = 0; i < 4; i++) begin
            par4[i] = ~^w[8*i +: 8];
        end
    endfunction

    function automatic logic [35:0] with_par(input logic [31:0] w);
        with_par = {par4(w), w};
    endfunction
endpackage

// ==== src/instruction_buffer_and_data_manipulation.sv ====
// datapath: fetched instruction latch, halfword selector, instruction hold,
// rotate/mask stage, duplicated alu with match check, bypass, zero finder,
// hardware and system status words.
// assumes the microcontrol sequencer drives strobes and the microinstruction
// word on core_clk_i, and returns general register data on source_bus_i.
//
// What this block does
// [RULE1] store select high loads latch from destination bus, low from memory data
// [RULE2] latch splits into upper half 31-16/p35,34 and lower 15-00/p33,32
// [RULE3] selector feeds hold register bit for bit and the opcode 4:1 mux
// [RULE4] hold register loads from destination bus or from the selector
// [RULE5] hold register parity checked continuously; error raises stop-and-switch
// [RULE6] hold register selects general register, rotation, and can drive source bus
// [RULE7] microword bits 43-40 and 15-12 pick the source bus register
// [RULE8] rotator turns the word right 0..31 places; zero leaves it alone
// [RULE9] parity is always regenerated after rotation
// [RULE10] one masking stage feeds both alu copies: inactive passes data, active screens bits
// [RULE11] mask comes from the instruction or an internal table
// [RULE12] table is 512x32; five low address bits shared with rotation amount
// [RULE13] one microword lead picks and (high) or or (low) gating
// [RULE14] mask one passes the data bit, mask zero forces zero
// [RULE15] both alu copies do the same add/sub/or/and/xor/pass together
// [RULE16] copy two drives the bus; copy one compares and flags a mismatch
// [RULE17] bus parity comes from copy one's result
// [RULE18] bypass copies source bus or microword field unchanged
// [RULE19] zero find puts the register on source bus and searches lowest zero
// [RULE20] bit 5 low means found, bits 4-0 give the position
// [RULE21] hardware status word loads from bus except read-only bits 7-4
// [RULE22] system status word mixes writable and read-only input bits
// [RULE23] compare error shows as fault latch bit 9, low when present; here there is no fault latch, only the active-low manip_err_n_o output
// [RULE24] no zero found drives all other bits to zero
// [RULE25] architectural registers load only on clock edge with their strobe; the status words' read-only bits follow the pin flops on every edge
module instruction_buffer_and_data_manipulation #(
    parameter logic [31:0] SSW_WR_MASK = dmu_pkg::SSW_WR_MASK_DEF
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic fil_load_i,
    input wire logic store_sel_i,
    input wire logic [35:0] mem_data_i,
    input wire logic cih_load_dst_i,
    input wire logic cih_load_hw_i,
    input wire logic [1:0] opcode_sel_i,
    input wire logic op_valid_i,
    input wire logic [dmu_pkg::MIR_W-1:0] mir_i,
    input wire logic [31:0] source_bus_i,
    input wire logic [31:0] operand_b_i,
    input wire logic hsw_load_i,
    input wire logic ssw_load_i,
    input wire logic [3:0] hsw_ro_pins_i,
    input wire logic [31:0] ssw_pins_i,
    output logic [35:0] dst_o,
    output logic [35:0] fil_o,
    output logic [35:0] cih_o,
    output logic [7:0] uaddr_seed_o,
    output logic [3:0] gen_reg_sel_o,
    output logic [31:0] hsw_o,
    output logic [31:0] ssw_o,
    output logic manip_err_n_o,
    output logic stop_switch_o
);
    import dmu_pkg::*;

    dmu_state_t r;
    dmu_state_t next_r;
    logic [35:0] hw_sel;
    logic [31:0] src_word;
    logic [31:0] rot_word;
    logic [31:0] mask;
    logic [31:0] gated;
    logic [31:0] alu0_res;
    logic [31:0] alu1_res;
    logic [31:0] flz_res;
    logic [4:0] rot_amt;
    logic [8:0] maddr;
    logic [3:0] reg_fld;
    logic [2:0] op;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // byte stage then bit stage, as the hardware does
    function automatic logic [31:0] rot_r(input logic [31:0] w, input logic [4:0] a);
        logic [63:0] t1;
        logic [63:0] t2;
        t1 = {w, w} >> {a[4:3], 3'b000};
        t2 = {t1[31:0], t1[31:0]} >> a[2:0];
        rot_r = t2[31:0];
    endfunction

    // mask table: four class bits, five amount bits; only eight classes used
    function automatic logic [31:0] mask_rom(input logic [8:0] a);
        logic [4:0] n;
        n = a[4:0];
        unique case (a[8:5])
            4'h0: mask_rom = 32'hffff_ffff;
            4'h1: mask_rom = ~(32'hffff_fffe << n);
            4'h2: mask_rom = 32'hffff_ffff << n;
            4'h3: mask_rom = 32'h0000_0001 << n;
            4'h4: mask_rom = 32'h0000_00ff << {n[4:3], 3'b000};
            4'h5: mask_rom = 32'h0000_ffff << {n[4], 4'b0000};
            4'h6: mask_rom = ~(32'h0000_0001 << n);
            4'h7: mask_rom = ~(32'hffff_fffe << n) & 32'h0000_ffff;
            default: mask_rom = 32'h0000_0000;
        endcase
    endfunction

    // one function feeds both copies; a fault in either shows up at the matcher
    function automatic logic [31:0] alu(input logic [2:0] o, input logic [31:0] a,
                                        input logic [31:0] b);
        unique case (o)
            OP_ADD: alu = a + b;
            OP_SUB: alu = a - b;
            OP_OR: alu = a | b;
            OP_AND: alu = a & b;
            OP_XOR: alu = a ^ b;
            default: alu = a;
        endcase
    endfunction

    // ------------------------------------------------------------
    // combinational datapath
    // ------------------------------------------------------------
    always_comb begin
        // selector passes the whole latch through; halves stay in place
        hw_sel = r.fil; // [RULE2] [RULE3]
        reg_fld = mir_i[MIR_REG_LO +: 4];
        unique case (mir_i[MIR_KIND_LO +: 4]) // [RULE7]
            KIND_CIH: src_word = r.cih[31:0]; // [RULE6]
            KIND_HSW: src_word = r.hsw;
            KIND_SSW: src_word = r.ssw;
            KIND_FIL: src_word = r.fil[31:0];
            default: src_word = source_bus_i;
        endcase
        maddr = mir_i[MIR_MADDR_LO +: 9];
        rot_amt = mir_i[MIR_ROT_CIH] ? r.cih[CIH_ROT_LO +: 5] : maddr[4:0]; // [RULE6] [RULE12]
        rot_word = rot_r(src_word, rot_amt); // [RULE8]
        mask = mir_i[MIR_MASK_CIH] ? r.cih[31:0] : mask_rom(maddr); // [RULE11] [RULE12]
        if (!mir_i[MIR_MASK_EN]) begin
            gated = rot_word; // [RULE10]
        end else if (mir_i[MIR_GATE_AND]) begin
            gated = rot_word & mask; // [RULE13] [RULE14]
        end else begin
            gated = (rot_word | operand_b_i) & mask; // [RULE13] [RULE14]
        end
        op = mir_i[MIR_OP_LO +: 3];
        alu0_res = alu(op, gated, operand_b_i); // [RULE15]
        alu1_res = alu(op, gated, operand_b_i); // [RULE15]
        flz_res = FLZ_NONE; // [RULE24]
        for (int i = 31; i >= 0; i--) begin
            if (!src_word[i]) begin
                flz_res = {27'h0, 5'(i)}; // [RULE19] [RULE20]
            end
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        // pins are asynchronous: two flops before the status words read them
        next_r.hro_s1 = hsw_ro_pins_i;
        next_r.hro_s2 = r.hro_s1;
        next_r.ssw_s1 = ssw_pins_i;
        next_r.ssw_s2 = r.ssw_s1;
        if (fil_load_i) begin
            next_r.fil = store_sel_i ? r.dst : mem_data_i; // [RULE1] [RULE25]
        end
        if (cih_load_dst_i) begin
            next_r.cih = r.dst; // [RULE4]
        end else if (cih_load_hw_i) begin
            next_r.cih = hw_sel; // [RULE3] [RULE4]
        end
        unique case (opcode_sel_i) // [RULE3]
            2'h0: next_r.uaddr = hw_sel[31:24];
            2'h1: next_r.uaddr = hw_sel[23:16];
            2'h2: next_r.uaddr = hw_sel[15:8];
            default: next_r.uaddr = hw_sel[7:0];
        endcase
        // hold parity checked every cycle, not only on load
        next_r.cih_perr = (par4(r.cih[31:0]) != r.cih[35:32]); // [RULE5]
        next_r.gen_sel = (reg_fld == REG_INDIRECT) ? r.cih[CIH_REG_LO +: 4] : reg_fld; // [RULE6]
        next_r.cmp_pend = 1'b0;
        if (op_valid_i) begin
            if (mir_i[MIR_FLZ]) begin
                next_r.dst = with_par(flz_res); // [RULE20] [RULE24]
            end else if (mir_i[MIR_BYPASS]) begin
                next_r.dst = mir_i[MIR_BYP_LIT] // [RULE18]
                    ? with_par({16'h0000, mir_i[MIR_LIT_LO +: 16]})
                    : with_par(src_word);
            end else begin
                // data from copy two, parity from copy one
                next_r.dst = {par4(alu0_res), alu1_res}; // [RULE9] [RULE16] [RULE17]
                next_r.alu0 = alu0_res;
                next_r.cmp_pend = 1'b1;
            end
        end
        // the match looks at the bus image one cycle after it is driven
        next_r.manip_err_n = r.cmp_pend ? (r.alu0 == r.dst[31:0]) : 1'b1; // [RULE16] [RULE23]
        if (hsw_load_i) begin
            next_r.hsw = r.dst[31:0] & ~HSW_RO_MASK; // [RULE21]
        end else begin
            next_r.hsw = r.hsw & ~HSW_RO_MASK;
        end
        next_r.hsw[7:4] = r.hro_s2; // [RULE21]
        if (ssw_load_i) begin
            next_r.ssw = (r.dst[31:0] & SSW_WR_MASK) | (r.ssw_s2 & ~SSW_WR_MASK); // [RULE22]
        end else begin
            next_r.ssw = (r.ssw & SSW_WR_MASK) | (r.ssw_s2 & ~SSW_WR_MASK); // [RULE22]
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
            r.dst <= BUS_RST;
            r.fil <= BUS_RST;
            r.cih <= BUS_RST;
            r.manip_err_n <= 1'b1;
        end else begin
            r <= next_r; // [RULE25]
        end
    end

    assign dst_o = r.dst;
    assign fil_o = r.fil;
    assign cih_o = r.cih;
    assign uaddr_seed_o = r.uaddr;
    assign gen_reg_sel_o = r.gen_sel;
    assign hsw_o = r.hsw;
    assign ssw_o = r.ssw;
    assign manip_err_n_o = r.manip_err_n;
    assign stop_switch_o = r.cih_perr;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    AST_FIL_FROM_DST: assert property (fil_load_i && store_sel_i |=> fil_o == $past(r.dst)) // [RULE1]
        else $error("latch did not take destination bus");
    AST_FIL_FROM_MEM: assert property (fil_load_i && !store_sel_i |=> fil_o == $past(mem_data_i)) // [RULE1]
        else $error("latch did not take memory data");
    AST_CIH_FROM_SEL: assert property (cih_load_hw_i && !cih_load_dst_i |=> cih_o == $past(fil_o)) // [RULE3]
        else $error("hold register differs from selector");
    AST_CIH_STILL: assert property (!cih_load_dst_i && !cih_load_hw_i |=> $stable(cih_o)) // [RULE25]
        else $error("hold register changed without strobe");
    AST_PAR_STOP: assert property (par4(cih_o[31:0]) != cih_o[35:32] |=> stop_switch_o) // [RULE5]
        else $error("hold parity error not raised");
    AST_DST_PARITY: assert property (dst_o[35:32] == par4(dst_o[31:0])) // [RULE17]
        else $error("destination parity wrong");
    AST_ROT_ZERO: assert property (op_valid_i && mir_i[8:3] == 6'h0 && op == OP_PASS
        && rot_amt == 5'h0 |=> dst_o[31:0] == $past(src_word)) // [RULE8]
        else $error("zero rotation altered data");
    AST_FLZ_NONE: assert property (op_valid_i && mir_i[MIR_FLZ] && src_word == 32'hffff_ffff
        |=> dst_o[31:0] == FLZ_NONE) // [RULE24]
        else $error("no-zero result wrong");
    AST_FLZ_LOW: assert property (op_valid_i && mir_i[MIR_FLZ] && !src_word[0]
        |=> dst_o[5:0] == 6'h00) // [RULE20]
        else $error("lowest zero position wrong");
    // both alu copies share one expression, so a mismatch needs a real fault
    AST_MATCH: assert property (r.cmp_pend && (r.alu0 != r.dst[31:0]) |=> !manip_err_n_o) // [RULE23]
        else $error("match flag wrong");
    AST_MATCH_IDLE: assert property (!r.cmp_pend |=> manip_err_n_o) // [RULE16]
        else $error("match flag low without an alu result");
    AST_CIH_FROM_DST: assert property (cih_load_dst_i |=> cih_o == $past(r.dst)) // [RULE4]
        else $error("hold register did not take destination bus");
    AST_DST_HOLD: assert property (!op_valid_i |=> $stable(dst_o)) // [RULE25]
        else $error("destination bus changed without an operation");
    AST_MASK_OFF: assert property (op_valid_i && !mir_i[MIR_MASK_EN] && op == OP_PASS // [RULE10]
        && !mir_i[MIR_FLZ] && !mir_i[MIR_BYPASS] |=> dst_o[31:0] == $past(rot_word))
        else $error("inactive mask altered data");
    AST_MASK_ZERO: assert property (op_valid_i && mir_i[MIR_MASK_EN] && op == OP_PASS // [RULE14]
        && !mir_i[MIR_FLZ] && !mir_i[MIR_BYPASS] |=> (dst_o[31:0] & ~$past(mask)) == 32'h0)
        else $error("masked-out bit reached the alu");
    AST_FLZ_FOUND: assert property (op_valid_i && mir_i[MIR_FLZ] // [RULE20]
        && src_word != 32'hffff_ffff |=> !dst_o[5])
        else $error("zero finder missed a zero");
    AST_UADDR_HI: assert property (opcode_sel_i == 2'h0 |=> uaddr_seed_o == $past(r.fil[31:24])) // [RULE3]
        else $error("opcode byte not taken from top byte");
    AST_GEN_INDIRECT: assert property (reg_fld == REG_INDIRECT // [RULE6]
        |=> gen_reg_sel_o == $past(r.cih[CIH_REG_LO +: 4]))
        else $error("indirect register select wrong");
    AST_HSW_WRITE: assert property (hsw_load_i // [RULE21]
        |=> (hsw_o & ~HSW_RO_MASK) == ($past(r.dst[31:0]) & ~HSW_RO_MASK))
        else $error("hardware status write lost");
    AST_SSW_RO: assert property (1'b1 // [RULE22]
        |=> (ssw_o & ~SSW_WR_MASK) == ($past(r.ssw_s2) & ~SSW_WR_MASK))
        else $error("system status read-only bits wrong");
    AST_HSW_RO: assert property (hsw_load_i |=> hsw_o[7:4] == $past(r.hro_s2)) // [RULE21]
        else $error("read-only status bits written");
    AST_BYP_LIT: assert property (op_valid_i && !mir_i[MIR_FLZ] && mir_i[MIR_BYPASS]
        && mir_i[MIR_BYP_LIT] |=> dst_o[31:0] == {16'h0000, $past(mir_i[31:16])}) // [RULE18]
        else $error("bypass literal altered");

    COV_ALU_ADD: cover property (op_valid_i && op == OP_ADD && mir_i[MIR_MASK_EN]);
    COV_FLZ: cover property (op_valid_i && mir_i[MIR_FLZ] ##1 !dst_o[5]);
    COV_BYPASS: cover property (op_valid_i && mir_i[MIR_BYPASS] && !mir_i[MIR_FLZ]);
    COV_STOP: cover property (stop_switch_o);
    COV_MASK_CIH: cover property (op_valid_i && mir_i[MIR_MASK_CIH] && mir_i[MIR_MASK_EN]
        && !mir_i[MIR_GATE_AND]);
endmodule

// ==== dv/dmu_store_model.sv ====
// partner model: general register file and cache/memory read port.
// assumes the bench sets the word to serve; read data is combinational.
module dmu_store_model (
    input wire logic [31:0] word_i,
    input wire logic bad_par_i,
    output logic [31:0] source_bus_o,
    output logic [35:0] mem_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    always_comb begin
        source_bus_o = word_i;
        // odd parity per byte; bad_par_i spoils byte 0 on purpose
        mem_data_o = {~^word_i[31:24], ~^word_i[23:16], ~^word_i[15:8], ~^word_i[7:0],
                      word_i};
        mem_data_o[32] = mem_data_o[32] ^ bad_par_i;
    end
endmodule

// ==== dv/test_instruction_buffer_and_data_manipulation.sv ====
// self-checking bench for the instruction hold and data manipulation datapath.
// assumes the design package and the store partner model are compiled first.
module test_instruction_buffer_and_data_manipulation;
    timeunit 1ns;
    timeprecision 1ps;
    import dmu_pkg::*;
    logic core_clk_i = 0, rst_i = 1, fil_load_i = 0, store_sel_i = 0, bad_par = 0;
    logic cih_load_dst_i = 0, cih_load_hw_i = 0, op_valid_i = 0, hsw_load_i = 0, ssw_load_i = 0;
    logic [1:0] opcode_sel_i = 0;
    logic [47:0] mir_i = '0;
    logic [31:0] operand_b_i = 0, word = 0, ssw_pins_i = 0, a;
    logic [3:0] hsw_ro_pins_i = 0;
    logic [31:0] source_bus_i, hsw_o, ssw_o;
    logic [35:0] mem_data_i, dst_o, fil_o, cih_o;
    logic [3:0] gen_reg_sel_o;
    logic [7:0] uaddr_seed_o;
    logic manip_err_n_o, stop_switch_o;
    int err_total = 0, checked = 0;
    always #5 core_clk_i = ~core_clk_i;
    dmu_store_model part_u (.word_i(word), .bad_par_i(bad_par), .source_bus_o(source_bus_i),
        .mem_data_o(mem_data_i));
    instruction_buffer_and_data_manipulation dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .fil_load_i(fil_load_i), .store_sel_i(store_sel_i), .mem_data_i(mem_data_i),
        .cih_load_dst_i(cih_load_dst_i), .cih_load_hw_i(cih_load_hw_i),
        .opcode_sel_i(opcode_sel_i), .op_valid_i(op_valid_i), .mir_i(mir_i),
        .source_bus_i(source_bus_i), .operand_b_i(operand_b_i), .hsw_load_i(hsw_load_i),
        .ssw_load_i(ssw_load_i), .hsw_ro_pins_i(hsw_ro_pins_i), .ssw_pins_i(ssw_pins_i),
        .dst_o(dst_o), .fil_o(fil_o), .cih_o(cih_o), .uaddr_seed_o(uaddr_seed_o),
        .gen_reg_sel_o(gen_reg_sel_o), .hsw_o(hsw_o), .ssw_o(ssw_o),
        .manip_err_n_o(manip_err_n_o),
        .stop_switch_o(stop_switch_o));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [35:0] wp(input logic [31:0] w);
        wp = {~^w[31:24], ~^w[23:16], ~^w[15:8], ~^w[7:0], w};
    endfunction
    function automatic logic [47:0] mk(input logic [3:0] kind, input logic [8:0] ma,
                                       input logic [9:0] fl);
        mk = {4'h0, kind, 15'h0, ma, 4'h0, 2'h0, fl};
    endfunction
    task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] want);
        checked++;
        if (seen !== want) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, want, seen);
        end
    endtask
    task automatic run_op(input logic [47:0] m);
        @(negedge core_clk_i);
        mir_i = m;
        op_valid_i = 1;
        @(negedge core_clk_i);
        op_valid_i = 0;
    endtask
    task automatic pulse(ref logic s);
        @(negedge core_clk_i);
        s = 1;
        @(negedge core_clk_i);
        s = 0;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_alu();
        word = 32'h1234_5678;
        operand_b_i = 32'h0000_0001;
        for (int op = 0; op < 6; op++) begin
            run_op(mk(4'h0, 9'h0, 10'h020 | 10'(op)));
            case (op)
                1: a = word + 1;
                2: a = word - 1;
                3: a = word | 1;
                4: a = word & 1;
                5: a = word ^ 1;
                default: a = word;
            endcase
            chk("alu result", dst_o, wp(a));
            @(negedge core_clk_i);
            chk("match flag", 36'(manip_err_n_o), 36'h1);
        end
        operand_b_i = 0;
    endtask
    task automatic t_rot_mask();
        int amts[4] = '{0, 1, 13, 31};
        foreach (amts[i]) begin
            run_op(mk(4'h0, 9'(amts[i]), 10'h028));
            a = (word >> amts[i]) | (word << (32 - amts[i]));
            chk("rotated word", dst_o, wp(a));
        end
        // class 3 keeps one bit, its index shared with the rotation amount
        run_op(mk(4'h0, {4'h3, 5'd5}, 10'h028));
        a = ((word >> 5) | (word << 27)) & 32'h0000_0020;
        chk("masked word", dst_o, wp(a));
        run_op(mk(4'h0, {4'h1, 5'd7}, 10'h028));
        a = ((word >> 7) | (word << 25)) & 32'h0000_00ff;
        chk("low field mask", dst_o, wp(a));
    endtask
    task automatic t_bypass_flz();
        run_op(mk(4'h0, 9'h0, 10'h0c0) | {16'h0, 16'hbeef, 16'h0});
        chk("bypass literal", dst_o, wp(32'h0000_beef));
        run_op(mk(4'h0, 9'h0, 10'h040));
        chk("bypass source", dst_o, wp(word));
        word = 32'hffff_ff7f;
        run_op(mk(4'h0, 9'h0, 10'h100));
        chk("zero found", dst_o, wp(32'h0000_0007));
        word = 32'hffff_ffff;
        run_op(mk(4'h0, 9'h0, 10'h100));
        chk("no zero", dst_o, wp(32'h0000_0020));
    endtask
    task automatic t_status(input logic [31:0] w, input logic [31:0] eh, input logic [31:0] es);
        word = w;
        hsw_ro_pins_i = 4'ha;
        ssw_pins_i = 32'ha5a5_0000;
        run_op(mk(4'h0, 9'h0, 10'h040));
        pulse(hsw_load_i);
        pulse(ssw_load_i);
        repeat (3) @(negedge core_clk_i);
        chk("hardware status", 36'(hsw_o), 36'(eh));
        chk("system status", 36'(ssw_o), 36'(es));
        run_op(mk(4'h2, 9'h0, 10'h040));
        chk("hardware status on source", dst_o, wp(eh));
        run_op(mk(4'h3, 9'h0, 10'h040));
        chk("system status on source", dst_o, wp(es));
    endtask
    task automatic t_fetch();
        word = 32'h8142_c3e4;
        pulse(fil_load_i);
        chk("latch from memory", fil_o, wp(word));
        opcode_sel_i = 2'h2;
        pulse(cih_load_hw_i);
        chk("hold from selector", cih_o, wp(word));
        chk("opcode byte", 36'(uaddr_seed_o), 36'h0c3);
        mir_i = 48'h0000_0000_f000;
        @(negedge core_clk_i);
        chk("indirect register", 36'(gen_reg_sel_o), 36'h4);
        mir_i = 48'h0000_0000_3000;
        @(negedge core_clk_i);
        chk("direct register", 36'(gen_reg_sel_o), 36'h3);
        run_op(mk(4'h0, 9'h0, 10'h0c0) | {16'h0, 16'h5a5a, 16'h0});
        store_sel_i = 1;
        pulse(fil_load_i);
        store_sel_i = 0;
        chk("latch from bus", fil_o, wp(32'h0000_5a5a));
        pulse(cih_load_dst_i);
        chk("hold from bus", cih_o, wp(32'h0000_5a5a));
        run_op(mk(4'h1, 9'h0, 10'h020));
        chk("hold on source", dst_o, wp(32'h0000_5a5a));
        operand_b_i = 32'h0000_0002;
        run_op(mk(4'h0, 9'h0, 10'h218));
        a = (((word >> 26) | (word << 6)) | 32'h0000_0002) & 32'h0000_5a5a;
        chk("or gate with hold mask", dst_o, wp(a));
        operand_b_i = 0;
        chk("no stop", 36'(stop_switch_o), 36'h0);
        bad_par = 1;
        pulse(fil_load_i);
        pulse(cih_load_hw_i);
        @(negedge core_clk_i);
        chk("stop on bad parity", 36'(stop_switch_o), 36'h1);
        bad_par = 0;
        pulse(fil_load_i);
        pulse(cih_load_hw_i);
        @(negedge core_clk_i);
        chk("stop cleared", 36'(stop_switch_o), 36'h0);
    endtask
    // ------------------------------------------------------------
    // run and verdict
    // ------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #100us;
        err_total++;
        final_report();
    end
    initial begin
        repeat (5) @(negedge core_clk_i);
        chk("bus at reset", dst_o, 36'hf_0000_0000);
        chk("hold at reset", cih_o, 36'hf_0000_0000);
        rst_i = 0;
        t_alu();
        t_rot_mask();
        t_bypass_flz();
        t_status(32'hffff_ffff, 32'hffff_ffaf, 32'ha5a5_ffff);
        t_status(32'h0000_0000, 32'h0000_00a0, 32'ha5a5_0000);
        t_fetch();
        final_report();
    end
endmodule
